// [design/aux_pointer_indirect_agen.v]
// Pointer indirect address generator with its own extended pointer file
`timescale 1ns/1ps
`include "aux_ptr_agen_map.vh"
module aux_pointer_indirect_agen (
	input wire clk_in,
	input wire nrst_in,
	// Pointer loads
	input wire load_full_in,
	input wire load_low_in,
	input wire [3:0] load_sel_in,
	input wire [22:0] load_data_in,
	// Pointer readback
	input wire [3:0] read_sel_in,
	output reg [22:0] ptr_value_out,
	// Access request from the decoder
	input wire req_valid_in,
	input wire [1:0] access_type_in,
	input wire [3:0] ptr_sel_in,
	input wire [2:0] mod_op_in,
	input wire wide_in,
	input wire [2:0] bit_instr_in,
	input wire [1:0] bit_target_in,
	// Configuration
	input wire [15:0] status_word_two_in,
	input wire legacy_compat_bit_in,
	input wire [15:0] temp_reg0_in,
	input wire [15:0] circ_start_pair01_in,
	input wire [15:0] circ_start_pair23_in,
	input wire [15:0] circ_start_pair45_in,
	input wire [15:0] circ_start_pair67_in,
	input wire [15:0] circ_start_coef_in,
	input wire [15:0] circ_size_pair01_in,
	input wire [15:0] circ_size_pair23_in,
	input wire [15:0] circ_size_pair45_in,
	input wire [15:0] circ_size_pair67_in,
	input wire [15:0] circ_size_coef_in,
	// Results
	output reg addr_valid_out,
	output reg [1:0] addr_type_out,
	output reg [22:0] data_addr_out,
	output reg [15:0] bit_index_out,
	output reg [15:0] io_addr_out,
	output reg access_err_out
);

	// Decode and arithmetic are combinational; every result is registered
	// Eight extended pointers plus the coefficient pointer at index 8
	reg [22:0] ptr_reg [0:8];

	// Chosen pointer and the values derived from it
	reg [22:0] ptr_cur;
	reg [22:0] index_val;
	reg [22:0] step_val;
	reg [22:0] delta;
	reg [22:0] moved;
	reg [22:0] ea_ptr;
	reg [22:0] new_ptr;
	reg [22:0] data_addr;
	reg [15:0] circ_start;
	reg [15:0] circ_size;
	reg [15:0] bit_max;
	reg circ_on;
	reg is_pre;
	reg modifies;
	// Refusal flags of the current request
	reg op_err;
	reg bit_err;
	reg req_err;
	integer i;

	// Legal pointer number: the eight pointers or the coefficient pointer
	function ptr_ok;
		input [3:0] sel;
		begin
			ptr_ok = (sel <= `COEF_SEL);
		end
	endfunction

	// Negation on the full 23-bit width; wraps like the pointer arithmetic
	function [22:0] neg23;
		input [22:0] v;
		begin
			neg23 = 23'h000000 - v;
		end
	endfunction

	// Modulo step inside a circular buffer; size zero falls back to a plain step.
	// Only correct for steps smaller than the buffer, which the software must keep.
	function [15:0] circ_add;
		input [15:0] v;
		input [16:0] d;
		input [15:0] sz;
		reg [17:0] s;
		begin
			s = {2'h0, v} + {d[16], d};
			if (sz == 16'h0000) begin
				circ_add = s[15:0];
			end else if (s[17]) begin
				s = s + {2'h0, sz};
				circ_add = s[15:0];
			end else if (s >= {2'h0, sz}) begin
				s = s - {2'h0, sz};
				circ_add = s[15:0];
			end else begin
				circ_add = s[15:0];
			end
		end
	endfunction

	// Pick circular setting, start and size for the chosen pointer
	always @* begin
		// Out-of-range numbers read zero instead of an undefined word
		if (ptr_ok(ptr_sel_in)) begin
			ptr_cur = ptr_reg[ptr_sel_in];
		end else begin
			ptr_cur = `PTR_RESET;
		end
		if (ptr_sel_in == `COEF_SEL) begin
			circ_on = status_word_two_in[`SW2_COEF_CIRC];
			circ_start = circ_start_coef_in;
			circ_size = circ_size_coef_in;
		end else begin
			circ_on = status_word_two_in[ptr_sel_in[2:0]];
			// Pointers share start and size in pairs, so bits 2:1 pick the pair
			case (ptr_sel_in[2:1])
				2'h0: begin
					circ_start = circ_start_pair01_in;
					circ_size = circ_size_pair01_in;
				end
				2'h1: begin
					circ_start = circ_start_pair23_in;
					circ_size = circ_size_pair23_in;
				end
				2'h2: begin
					circ_start = circ_start_pair45_in;
					circ_size = circ_size_pair45_in;
				end
				default: begin
					circ_start = circ_start_pair67_in;
					circ_size = circ_size_pair67_in;
				end
			endcase
		end
	end

	// Step, index and signed delta for the modification
	always @* begin
		step_val = wide_in ? `STEP_WIDE : `STEP_NARROW;
		// Sign extension lets a negative temp step down across pages
		if (legacy_compat_bit_in) begin
			index_val = ptr_reg[0];
		end else begin
			index_val = {{7{temp_reg0_in[15]}}, temp_reg0_in};
		end
		is_pre = 1'b0;
		modifies = 1'b1;
		case (mod_op_in)
			`OP_POST_INC: delta = step_val;
			`OP_POST_DEC: delta = neg23(step_val);
			`OP_PRE_INC: begin
				delta = step_val;
				is_pre = 1'b1;
			end
			`OP_PRE_DEC: begin
				delta = neg23(step_val);
				is_pre = 1'b1;
			end
			`OP_POST_ADD_IDX: delta = index_val;
			`OP_POST_SUB_IDX: delta = neg23(index_val);
			`OP_BASE_IDX: begin
				delta = index_val;
				is_pre = 1'b1;
				modifies = 1'b0;
			end
			default: begin
				delta = 23'h000000;
				modifies = 1'b0;
			end
		endcase
	end

	// Control operand set offers only plain, post-step and base-plus-index operands
	always @* begin
		// A refused request is still answered, so the decoder never waits
		op_err = 1'b0;
		if (status_word_two_in[`SW2_OPSET]) begin
			case (mod_op_in)
				`OP_NONE: op_err = 1'b0;
				`OP_POST_INC: op_err = 1'b0;
				`OP_POST_DEC: op_err = 1'b0;
				`OP_BASE_IDX: op_err = 1'b0;
				default: op_err = 1'b1;
			endcase
		end
	end

	// Moved pointer by circular setting, then access type; only non-circular data keeps the high part in the sum
	always @* begin
		if (circ_on) begin
			moved = {ptr_cur[22:16], circ_add(ptr_cur[15:0], delta[16:0], circ_size)};
		end else if (access_type_in == `ACC_DATA) begin
			moved = ptr_cur + delta;
		end else begin
			// Bit and I/O pointers keep the high part; the low word wraps
			moved = {ptr_cur[22:16], ptr_cur[15:0] + delta[15:0]};
		end
		// Pre forms address with the moved value, post forms with the old one
		ea_ptr = is_pre ? moved : ptr_cur;
		new_ptr = modifies ? moved : ptr_cur;
		if (circ_on) begin
			// Start offset joins the address only, never the stored pointer
			data_addr = {ea_ptr[22:16], 16'h0000} + {7'h00, circ_start} +
				{7'h00, ea_ptr[15:0]};
		end else begin
			data_addr = ea_ptr;
		end
	end

	// Register-bit legality: instruction class, target class, top bit
	always @* begin
		bit_max = (bit_target_in == `TGT_ACC) ? `BIT_MAX_ACC : `BIT_MAX_NARROW;
		bit_err = 1'b0;
		if (access_type_in == `ACC_BIT) begin
			case (bit_instr_in)
				`BIT_TEST: bit_err = 1'b0;
				`BIT_SET: bit_err = 1'b0;
				`BIT_CLEAR: bit_err = 1'b0;
				`BIT_CPL: bit_err = 1'b0;
				default: bit_err = 1'b1;
			endcase
			if (bit_target_in == `TGT_OTHER) begin
				bit_err = 1'b1;
			end
			// A bit pair needs room for the next bit, so the top index is refused
			if (wide_in && (ea_ptr[15:0] >= bit_max)) begin
				bit_err = 1'b1;
			end else if (ea_ptr[15:0] > bit_max) begin
				bit_err = 1'b1;
			end
		end
		// Access type 3 names no space and is refused
		req_err = bit_err | op_err | (access_type_in == 2'h3);
	end

	// Pointer file: loads, and write-back of the access that uses the pointer
	always @(posedge clk_in) begin
		if (!nrst_in) begin
			// All nine pointers clear together
			for (i = 0; i < 9; i = i + 1) begin
				ptr_reg[i] <= `PTR_RESET;
			end
		end else begin
			// Access write-back beats a load to the same pointer in one cycle
			if (load_full_in && ptr_ok(load_sel_in)) begin
				ptr_reg[load_sel_in] <= load_data_in;
			end else if (load_low_in && ptr_ok(load_sel_in)) begin
				ptr_reg[load_sel_in] <= {ptr_reg[load_sel_in][22:16],
					load_data_in[15:0]};
			end
			// Refused requests leave the pointer as it was
			if (req_valid_in && !req_err && ptr_ok(ptr_sel_in)) begin
				ptr_reg[ptr_sel_in] <= new_ptr;
			end
		end
	end

	// One result per request, held until the next request
	// Refused requests still answer, with the error flag set
	always @(posedge clk_in) begin
		if (!nrst_in) begin
			addr_valid_out <= 1'b0;
			addr_type_out <= `ACC_DATA;
			data_addr_out <= 23'h000000;
			bit_index_out <= 16'h0000;
			io_addr_out <= 16'h0000;
			access_err_out <= 1'b0;
			ptr_value_out <= 23'h000000;
		end else begin
			// Readback is registered like every other output
			if (ptr_ok(read_sel_in)) begin
				ptr_value_out <= ptr_reg[read_sel_in];
			end else begin
				ptr_value_out <= 23'h000000;
			end
			addr_valid_out <= req_valid_in;
			if (req_valid_in) begin
				addr_type_out <= access_type_in;
				access_err_out <= req_err | !ptr_ok(ptr_sel_in);
				// Unused result ports read zero so no consumer sees a stale address
				data_addr_out <= 23'h000000;
				bit_index_out <= 16'h0000;
				io_addr_out <= 16'h0000;
				case (access_type_in)
					`ACC_DATA: data_addr_out <= data_addr;
					`ACC_BIT: bit_index_out <= ea_ptr[15:0];
					`ACC_IO: io_addr_out <= ea_ptr[15:0];
					default: access_err_out <= 1'b1;
				endcase
			end
		end
	end

endmodule // aux_pointer_indirect_agen

// [design/aux_ptr_agen_map.vh]
// Constants for the pointer indirect address generator
`ifndef AUX_PTR_AGEN_MAP_VH
`define AUX_PTR_AGEN_MAP_VH
// Access types
`define ACC_DATA 2'h0
`define ACC_BIT 2'h1
`define ACC_IO 2'h2
// Pointer modification codes
`define OP_NONE 3'h0
`define OP_POST_INC 3'h1
`define OP_POST_DEC 3'h2
`define OP_PRE_INC 3'h3
`define OP_PRE_DEC 3'h4
`define OP_POST_ADD_IDX 3'h5
`define OP_POST_SUB_IDX 3'h6
`define OP_BASE_IDX 3'h7
// Bit instruction classes and target classes
`define BIT_TEST 3'h0
`define BIT_SET 3'h1
`define BIT_CLEAR 3'h2
`define BIT_CPL 3'h3
`define TGT_ACC 2'h0
`define TGT_PTR 2'h1
`define TGT_TEMP 2'h2
`define TGT_OTHER 2'h3
`define BIT_MAX_ACC 16'h0027
`define BIT_MAX_NARROW 16'h000f
// Status word two field positions
`define SW2_COEF_CIRC 8
`define SW2_OPSET 15
// Pointer file
`define COEF_SEL 4'h8
`define STEP_NARROW 23'h000001
`define STEP_WIDE 23'h000002
`define PTR_RESET 23'h000000
`endif

// [testbench/aux_agen_asserts.sv]
// Checker for the pointer address generator ports
`timescale 1ns/1ps
module aux_agen_asserts (
	input wire clk_in,
	input wire nrst_in,
	input wire req_valid_in,
	input wire [1:0] access_type_in,
	input wire [2:0] mod_op_in,
	input wire [2:0] bit_instr_in,
	input wire [1:0] bit_target_in,
	input wire [15:0] status_word_two_in,
	input wire addr_valid_out,
	input wire [1:0] addr_type_out,
	input wire [22:0] data_addr_out,
	input wire access_err_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	// Request and answer pairing
	property p_ans; req_valid_in |=> addr_valid_out; endproperty
	a_ans: assert property (p_ans) else $error("no answer");
	property p_idle; !req_valid_in |=> !addr_valid_out; endproperty
	a_idle: assert property (p_idle) else $error("stray answer");
	property p_type; req_valid_in && access_type_in != 2'h3 |=>
		addr_type_out == $past(access_type_in); endproperty
	a_type: assert property (p_type) else $error("wrong type");
	property p_bad_type; req_valid_in && access_type_in == 2'h3 |=> access_err_out; endproperty
	a_bad_type: assert property (p_bad_type) else $error("type not refused");
	// Control operand set refuses pre and post-index forms
	property p_opset; req_valid_in && status_word_two_in[15] &&
		mod_op_in inside {3'h3, 3'h4, 3'h5, 3'h6} |=> access_err_out; endproperty
	a_opset: assert property (p_opset) else $error("op not refused");
	property p_bit; req_valid_in && access_type_in == 2'h1 &&
		(bit_instr_in > 3'h3 || bit_target_in == 2'h3) |=> access_err_out; endproperty
	a_bit: assert property (p_bit) else $error("bit op not refused");
	// Results hold while no request comes
	property p_hold; !req_valid_in |=> $stable(data_addr_out) && $stable(access_err_out);
	endproperty
	a_hold: assert property (p_hold) else $error("result moved");
	property p_unused; addr_valid_out && addr_type_out != 2'h0 |-> data_addr_out == 23'h0;
	endproperty
	a_unused: assert property (p_unused) else $error("unused result set");
	c_io: cover property (addr_valid_out && addr_type_out == 2'h2);
	c_bit: cover property (addr_valid_out && addr_type_out == 2'h1);
	c_err: cover property (addr_valid_out && access_err_out);
endmodule // aux_agen_asserts

// [testbench/decoder_model.sv]
// Instruction decoder model issuing one request at a time
`timescale 1ns/1ps
module decoder_model (
	input wire clk_in,
	output reg req_valid_out,
	output reg [1:0] access_type_out,
	output reg [3:0] ptr_sel_out,
	output reg [2:0] mod_op_out,
	output reg wide_out,
	output reg [2:0] bit_instr_out,
	output reg [1:0] bit_target_out
);
	initial {req_valid_out, access_type_out, ptr_sel_out, mod_op_out} = 10'h0;
	initial {wide_out, bit_instr_out, bit_target_out} = 6'h0;
	// One-cycle request; fields inverted after so stale values never pass
	task issue(input [1:0] t, input [3:0] s, input [2:0] o, input w, input [2:0] bi,
		input [1:0] bt);
		@(negedge clk_in);
		{req_valid_out, access_type_out, ptr_sel_out, mod_op_out} = {1'b1, t, s, o};
		{wide_out, bit_instr_out, bit_target_out} = {w, bi, bt};
		@(negedge clk_in);
		{req_valid_out, access_type_out, ptr_sel_out, mod_op_out} = {1'b0, ~t, ~s, ~o};
		{wide_out, bit_instr_out, bit_target_out} = {~w, ~bi, ~bt};
	endtask
endmodule // decoder_model

// [testbench/testbench.sv]
// Self-checking bench for the pointer address generator
`timescale 1ns/1ps
`include "aux_ptr_agen_map.vh"
module testbench;
	reg clk_in = 0, nrst_in = 0, load_full_in = 0, load_low_in = 0, legacy = 0;
	reg [3:0] load_sel_in = 0, read_sel_in = 0;
	reg [22:0] load_data_in = 0;
	reg [15:0] sw2 = 0, temp0 = 0, cstart = 0, csize = 0;
	wire rv, wd, av, err;
	wire [1:0] at, bt, ot;
	wire [3:0] ps;
	wire [2:0] mo, bi;
	wire [22:0] pv, da;
	wire [15:0] bx, io;
	integer err_total = 0, n_checks = 0, i;
	always #25 clk_in = ~clk_in;
	decoder_model decoder_model_inst (.clk_in(clk_in), .req_valid_out(rv),
		.access_type_out(at), .ptr_sel_out(ps), .mod_op_out(mo), .wide_out(wd),
		.bit_instr_out(bi), .bit_target_out(bt));
	aux_pointer_indirect_agen aux_pointer_indirect_agen_inst (.clk_in(clk_in),
		.nrst_in(nrst_in), .load_full_in(load_full_in), .load_low_in(load_low_in),
		.load_sel_in(load_sel_in), .load_data_in(load_data_in), .read_sel_in(read_sel_in),
		.ptr_value_out(pv), .req_valid_in(rv), .access_type_in(at), .ptr_sel_in(ps),
		.mod_op_in(mo), .wide_in(wd), .bit_instr_in(bi), .bit_target_in(bt),
		.status_word_two_in(sw2), .legacy_compat_bit_in(legacy), .temp_reg0_in(temp0),
		.circ_start_pair01_in(cstart), .circ_start_pair23_in(cstart),
		.circ_start_pair45_in(cstart), .circ_start_pair67_in(cstart),
		.circ_start_coef_in(cstart), .circ_size_pair01_in(csize),
		.circ_size_pair23_in(csize), .circ_size_pair45_in(csize),
		.circ_size_pair67_in(csize), .circ_size_coef_in(csize), .addr_valid_out(av),
		.addr_type_out(ot), .data_addr_out(da), .bit_index_out(bx), .io_addr_out(io),
		.access_err_out(err));
	task chk(input [22:0] got, input [22:0] exp);
		n_checks = n_checks + 1;
		if (got !== exp) begin
			err_total = err_total + 1;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Load a pointer whole or low half, one cycle
	task ld(input full, input [3:0] s, input [22:0] d);
		@(negedge clk_in);
		{load_full_in, load_low_in, load_sel_in, load_data_in} = {full, ~full, s, d};
		@(negedge clk_in);
		{load_full_in, load_low_in, load_data_in} = {2'b00, ~d};
	endtask
	task rd(input [3:0] s, input [22:0] exp);
		@(negedge clk_in);
		read_sel_in = s;
		@(negedge clk_in);
		chk(pv, exp);
	endtask
	// One access; the result port compared follows the access type
	task acc(input [1:0] t, input [3:0] s, input [2:0] o, input w, input [2:0] b,
		input [1:0] g, input [22:0] exp, input e);
		decoder_model_inst.issue(t, s, o, w, b, g);
		chk(av, 1);
		chk(ot, t);
		chk(err, e);
		if (!e)
			chk(t == 2'h0 ? da : t == 2'h1 ? {7'h0, bx} : {7'h0, io}, exp);
	endtask
	task end_sim;
		$display("checks=%0d errors=%0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		err_total = err_total + 1;
		end_sim;
	end
	initial begin
		repeat (20) @(negedge clk_in);
		nrst_in = 1;
		ld(1, 4'h2, 23'h03fffe);
		acc(`ACC_DATA, 4'h2, `OP_POST_INC, 0, 0, 0, 23'h03fffe, 0);
		acc(`ACC_DATA, 4'h2, `OP_POST_INC, 1, 0, 0, 23'h03ffff, 0);
		acc(`ACC_DATA, 4'h2, `OP_PRE_INC, 1, 0, 0, 23'h040003, 0);
		ld(0, 4'h2, 23'h001234);
		rd(4'h2, 23'h041234);
		ld(1, 4'h3, 23'h00ffff);
		acc(`ACC_IO, 4'h3, `OP_POST_INC, 0, 0, 0, 23'h00ffff, 0);
		acc(`ACC_IO, 4'h3, `OP_NONE, 0, 0, 0, 23'h000000, 0);
		rd(4'h3, 23'h000000);
		ld(1, 4'h4, 23'h000027);
		for (i = 0; i < 4; i = i + 1)
			acc(`ACC_BIT, 4'h4, `OP_NONE, 0, i, `TGT_ACC, 23'h000027, 0);
		acc(`ACC_BIT, 4'h4, `OP_NONE, 0, `BIT_CPL, `TGT_OTHER, 23'h0, 1);
		acc(`ACC_BIT, 4'h4, `OP_NONE, 0, 3'h4, `TGT_TEMP, 23'h0, 1);
		acc(`ACC_BIT, 4'h4, `OP_NONE, 1, `BIT_TEST, `TGT_ACC, 23'h0, 1);
		acc(`ACC_BIT, 4'h4, `OP_NONE, 0, `BIT_SET, `TGT_TEMP, 23'h0, 1);
		ld(1, 4'h4, 23'h00000f);
		acc(`ACC_BIT, 4'h4, `OP_NONE, 0, `BIT_CLEAR, `TGT_PTR, 23'h00000f, 0);
		acc(2'h3, 4'h4, `OP_NONE, 0, 0, 0, 23'h0, 1);
		sw2 = 16'h8000;
		acc(`ACC_DATA, 4'h2, `OP_PRE_INC, 0, 0, 0, 23'h0, 1);
		acc(`ACC_DATA, 4'h2, `OP_POST_INC, 0, 0, 0, 23'h041234, 0);
		{sw2, cstart, csize} = {16'h0001, 16'h0100, 16'h0008};
		ld(1, `COEF_SEL, 23'h7f0010);
		acc(`ACC_DATA, `COEF_SEL, `OP_POST_DEC, 0, 0, 0, 23'h7f0010, 0);
		acc(`ACC_DATA, `COEF_SEL, `OP_PRE_DEC, 0, 0, 0, 23'h7f000e, 0);
		ld(1, 4'h0, 23'h010005);
		acc(`ACC_DATA, 4'h0, `OP_POST_INC, 0, 0, 0, 23'h010105, 0);
		acc(`ACC_DATA, 4'h0, `OP_NONE, 0, 0, 0, 23'h010106, 0);
		acc(`ACC_DATA, 4'h1, `OP_NONE, 0, 0, 0, 23'h000000, 0);
		ld(1, 4'h0, 23'h010007);
		acc(`ACC_DATA, 4'h0, `OP_POST_INC, 0, 0, 0, 23'h010107, 0);
		acc(`ACC_DATA, 4'h0, `OP_NONE, 0, 0, 0, 23'h010100, 0);
		{sw2, temp0} = {16'h0000, 16'hfffe};
		ld(1, 4'h5, 23'h010000);
		acc(`ACC_DATA, 4'h5, `OP_POST_ADD_IDX, 0, 0, 0, 23'h010000, 0);
		legacy = 1;
		acc(`ACC_DATA, 4'h5, `OP_POST_ADD_IDX, 0, 0, 0, 23'h00fffe, 0);
		acc(`ACC_DATA, 4'h5, `OP_NONE, 0, 0, 0, 23'h01fffe, 0);
		legacy = 0;
		acc(`ACC_DATA, 4'h5, `OP_BASE_IDX, 0, 0, 0, 23'h01fffc, 0);
		acc(`ACC_DATA, 4'h5, `OP_POST_SUB_IDX, 0, 0, 0, 23'h01fffe, 0);
		acc(`ACC_DATA, 4'h5, `OP_PRE_DEC, 1, 0, 0, 23'h01fffe, 0);
		rd(4'h5, 23'h01fffe);
		end_sim;
	end
endmodule // testbench
bind aux_pointer_indirect_agen aux_agen_asserts aux_agen_asserts_inst (.clk_in(clk_in),
	.nrst_in(nrst_in), .req_valid_in(req_valid_in), .access_type_in(access_type_in),
	.mod_op_in(mod_op_in), .bit_instr_in(bit_instr_in), .bit_target_in(bit_target_in),
	.status_word_two_in(status_word_two_in), .addr_valid_out(addr_valid_out),
	.addr_type_out(addr_type_out), .data_addr_out(data_addr_out),
	.access_err_out(access_err_out));
